// [rtl/iou_defs.vh]
// iou_defs.vh: constants for the immediate I/O access unit
// assumes: included by rtl design files by bare name
`ifndef IOU_DEFS_VH
`define IOU_DEFS_VH
// operation codes on op_i
`define IOU_OP_W          4
`define IOU_OP_NONE       4'h0
`define IOU_OP_COIL       4'h1
`define IOU_OP_SET        4'h2
`define IOU_OP_CLEAR      4'h3
`define IOU_OP_LDW        4'h4
`define IOU_OP_LDB        4'h5
`define IOU_OP_OUTW       4'h6
`define IOU_OP_OUTB       4'h7
`define IOU_OP_SERIES     4'h8
`define IOU_OP_SERIES_N   4'h9
// point space and data widths
`define IOU_PTS           1024
`define IOU_PT_W          10
`define IOU_ACC_W         32
`define IOU_WORD_W        16
`define IOU_WORD_CNT      6'h10
`define IOU_CNT_W         6
`define IOU_CNT_MAX       6'h20
`define IOU_CNT_MIN       6'h01
// word address window for word loads and writes (octal 40400..40477)
`define IOU_ADDR_W        15
`define IOU_WADDR_LO      15'h4100
`define IOU_WADDR_HI      15'h413F
`define IOU_WORD_SHIFT    4
`define IOU_ZERO_ACC      32'h00000000
`endif

// [rtl/iou_field.v]
// iou_field.v: contiguous bit-field extract and merge over the point space
// assumes: start and count already checked by the caller
`timescale 1ns/1ps
`include "iou_defs.vh"
module iou_field (
  input  wire [`IOU_PTS-1:0]   vec_i,
  input  wire [`IOU_PT_W-1:0]  start_i,
  input  wire [`IOU_CNT_W-1:0] count_i,
  input  wire [`IOU_ACC_W-1:0] bits_i,
  output wire [`IOU_ACC_W-1:0] field_o,
  output wire [`IOU_PTS-1:0]   mask_o,
  output wire [`IOU_PTS-1:0]   merged_o
);
  wire [`IOU_PTS-1:0]   cmask;
  wire [`IOU_PTS-1:0]   shifted;
  wire [`IOU_PTS-1:0]   wide_bits;
  // low mask of count ones, zero beyond the count
  assign cmask     = ~({`IOU_PTS{1'b1}} << count_i);
  assign shifted   = vec_i >> start_i;
  assign field_o   = shifted[`IOU_ACC_W-1:0] & cmask[`IOU_ACC_W-1:0];
  assign mask_o    = cmask << start_i;
  assign wide_bits = {{(`IOU_PTS-`IOU_ACC_W){1'b0}}, bits_i} << start_i;
  assign merged_o  = (vec_i & ~mask_o) | (wide_bits & mask_o);
endmodule // iou_field

// [rtl/iou_unit.v]
// iou_unit.v: immediate I/O access path between sequencer and I/O modules
// assumes: one op per cycle pulse from sequencer; inputs synchronous
// What this block does
// - coil turns point on if any rung naming it is true, ored.
// - set drives one point or a range on at the module now.
// - set points stay on after the rung drops, until cleared.
// - clear drives points off now, image untouched, and they stay off.
// - word load puts live 16 input points into the accumulator.
// - word load accepts only local-base word addresses 40400..40477.
// - bit load reads 1..32 contiguous input points from a start point.
// - accumulator bits above the bit count are forced to zero.
// - word write drives accumulator low 16 bits to a local output word.
// - bit write drives 1..32 low accumulator bits to contiguous outputs.
// - series contact takes live input state, inverted for negated form.
`timescale 1ns/1ps
`include "iou_defs.vh"
module iou_unit (
  input  wire                   core_clk_i,
  input  wire                   rst_i,
  input  wire                   op_valid_i,
  input  wire [`IOU_OP_W-1:0]   op_i,
  input  wire                   rung_i,
  input  wire [`IOU_PT_W-1:0]   point_i,
  input  wire [`IOU_PT_W-1:0]   last_i,
  input  wire [`IOU_CNT_W-1:0]  count_i,
  input  wire [`IOU_ADDR_W-1:0] waddr_i,
  input  wire                   scan_start_i,
  input  wire [`IOU_ACC_W-1:0]  acc_i,
  input  wire [`IOU_PTS-1:0]    in_pts_i,
  output wire                   op_ready_o,
  output reg                    done_o,
  output reg                    error_o,
  output reg                    acc_we_o,
  output reg  [`IOU_ACC_W-1:0]  acc_o,
  output reg                    contact_o,
  output reg  [`IOU_PTS-1:0]    out_pts_o
);
  reg  [`IOU_PTS-1:0]    out_d;
  reg  [`IOU_PTS-1:0]    coil_q;
  reg  [`IOU_PTS-1:0]    coil_d;
  reg  [`IOU_ACC_W-1:0]  acc_d;
  reg                    acc_we_d;
  reg                    err_d;
  reg                    contact_d;
  reg  [`IOU_PT_W-1:0]   f_start;
  reg  [`IOU_CNT_W-1:0]  f_count;
  reg  [`IOU_PTS-1:0]    f_vec;
  reg  [`IOU_ACC_W-1:0]  f_bits;
  wire [`IOU_ACC_W-1:0]  f_field;
  wire [`IOU_PTS-1:0]    f_mask;
  wire [`IOU_PTS-1:0]    f_merged;
  wire [`IOU_PTS-1:0]    range_mask;
  wire [`IOU_PTS-1:0]    lo_mask;
  wire [`IOU_PTS-1:0]    hi_mask;
  wire [`IOU_PTS-1:0]    pt_bit;
  wire [`IOU_ADDR_W-1:0] woff;
  wire                   waddr_ok;
  wire                   cnt_ok;
  wire                   go;

  // every operation is accepted in the cycle it is presented; its results register one cycle later
  assign op_ready_o = 1'b1;
  assign go         = op_valid_i;
  assign pt_bit     = {{(`IOU_PTS-1){1'b0}}, 1'b1} << point_i;
  // points from point_i to last_i inclusive; the mask is empty when
  // last_i lies below point_i, so such a range changes nothing
  assign lo_mask    = {`IOU_PTS{1'b1}} << point_i;
  assign hi_mask    = ~(({`IOU_PTS{1'b1}} << last_i) << 1);
  assign range_mask = lo_mask & hi_mask;
  // word offset, only meaningful inside the address window
  assign woff       = waddr_i - `IOU_WADDR_LO;
  assign waddr_ok   = (waddr_i >= `IOU_WADDR_LO) &&
                      (waddr_i <= `IOU_WADDR_HI);
  assign cnt_ok     = (count_i >= `IOU_CNT_MIN) &&
                      (count_i <= `IOU_CNT_MAX);

  // shared field extractor and merger
  iou_field u_field (
    .vec_i    (f_vec),
    .start_i  (f_start),
    .count_i  (f_count),
    .bits_i   (f_bits),
    .field_o  (f_field),
    .mask_o   (f_mask),
    .merged_o (f_merged)
  );

  // operand steering for the field unit
  // loads read the live input points, writes merge into the output points
  // word ops turn the word offset into a start point sixteen points apart
  always @* begin
    f_vec   = in_pts_i;
    f_start = point_i;
    f_count = count_i;
    f_bits  = acc_i;
    case (op_i)
      `IOU_OP_LDW: begin
        f_start = woff[`IOU_PT_W-1:0] << `IOU_WORD_SHIFT;
        f_count = `IOU_WORD_CNT;
      end

      `IOU_OP_OUTW: begin
        // only the low accumulator half reaches the word
        f_vec   = out_pts_o;
        f_start = woff[`IOU_PT_W-1:0] << `IOU_WORD_SHIFT;
        f_count = `IOU_WORD_CNT;
        f_bits  = {{(`IOU_ACC_W-`IOU_WORD_W){1'b0}},
                   acc_i[`IOU_WORD_W-1:0]};
      end

      `IOU_OP_OUTB: begin
        f_vec   = out_pts_o;
      end

      default: begin
        f_vec   = in_pts_i;
      end
    endcase
  end

  // next state of output points, accumulator and status
  // a scan start clears the coil memory before the op of that cycle counts
  always @* begin
    out_d     = out_pts_o;
    coil_d    = scan_start_i ? {`IOU_PTS{1'b0}} : coil_q;
    acc_d     = acc_o;
    acc_we_d  = 1'b0;
    err_d     = 1'b0;
    contact_d = contact_o;
    if (go) begin
      case (op_i)
        `IOU_OP_COIL: begin
          // any true rung this scan keeps the point on; a true rung in
          // the cycle of the scan start already counts for the new scan
          if (rung_i)
            coil_d = coil_d | pt_bit;
          if (rung_i || (coil_d & pt_bit) != {`IOU_PTS{1'b0}})
            out_d = out_pts_o | pt_bit;
          else
            out_d = out_pts_o & ~pt_bit;
        end

        `IOU_OP_SET: begin
          // a false rung leaves the latched points alone
          if (rung_i)
            out_d = out_pts_o | range_mask;
        end

        `IOU_OP_CLEAR: begin
          if (rung_i)
            out_d = out_pts_o & ~range_mask;
        end

        `IOU_OP_LDW: begin
          // a refused address leaves the accumulator as it was
          if (!waddr_ok)
            err_d = 1'b1;
          else if (rung_i) begin
            acc_d    = f_field;
            acc_we_d = 1'b1;
          end
        end

        `IOU_OP_LDB: begin
          if (!cnt_ok)
            err_d = 1'b1;
          else if (rung_i) begin
            acc_d    = f_field;
            acc_we_d = 1'b1;
          end
        end

        `IOU_OP_OUTW: begin
          if (!waddr_ok)
            err_d = 1'b1;
          else if (rung_i)
            out_d = f_merged;
        end

        `IOU_OP_OUTB: begin
          // points past the end of the point space are dropped
          if (!cnt_ok)
            err_d = 1'b1;
          else if (rung_i)
            out_d = f_merged;
        end

        `IOU_OP_SERIES: begin
          contact_d = rung_i & in_pts_i[point_i];
        end

        `IOU_OP_SERIES_N: begin
          contact_d = rung_i & ~in_pts_i[point_i];
        end

        default: begin
          err_d = 1'b1;
        end
      endcase
    end
  end

  // registers; outputs hold between operations, so set/clear latch
  // done, error and accumulator write are one-cycle pulses per op;
  // acc_o and contact_o keep their value until an op changes them
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      out_pts_o <= {`IOU_PTS{1'b0}};
      coil_q    <= {`IOU_PTS{1'b0}};
      acc_o     <= `IOU_ZERO_ACC;
      acc_we_o  <= 1'b0;
      error_o   <= 1'b0;
      done_o    <= 1'b0;
      contact_o <= 1'b0;
    end else begin
      out_pts_o <= out_d;
      coil_q    <= coil_d;
      acc_o     <= acc_d;
      acc_we_o  <= acc_we_d;
      error_o   <= err_d;
      done_o    <= go;
      contact_o <= contact_d;
    end
  end
endmodule // iou_unit

// [test/immediate_io_access_unit_tb_top.sv]
// tb top: directed and random immediate ops, results queued and compared
// assumes: iou_unit with one result pulse per op, one cycle later
`timescale 1ns/1ps
module immediate_io_access_unit_tb_top;
  logic clk = 0, rst = 1, ov = 0, rung = 0, scan = 0, nw = 0, ec = 0;
  logic [3:0] op = 0;
  logic [9:0] pt = 0, lst = 0;
  logic [5:0] cnt = 0;
  logic [14:0] wa = 0;
  logic [31:0] acc = 0, ea = 0, acc_o;
  logic [1023:0] pts, out_pts, eo = 0, cm = 0;
  logic done, err, we, con;
  logic [1058:0] q[$];
  logic [1058:0] nt;
  int fail_count = 0, total_checks = 0;
  always #4 clk = ~clk;
  iou_io_mod u_io (.clk_i(clk), .new_i(nw), .pts_o(pts));
  iou_unit u_dut (.core_clk_i(clk), .rst_i(rst), .op_valid_i(ov),
    .op_i(op), .rung_i(rung), .point_i(pt), .last_i(lst), .count_i(cnt),
    .waddr_i(wa), .scan_start_i(scan), .acc_i(acc), .in_pts_i(pts),
    .op_ready_o(), .done_o(done), .error_o(err), .acc_we_o(we),
    .acc_o(acc_o), .contact_o(con), .out_pts_o(out_pts));
  task chk(input string nm, input logic [1058:0] s,
           input logic [1058:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task report_and_stop;
    if (fail_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // each completed op against the oldest note
  always @(posedge clk) if (!rst && (done || err)) begin
    if (q.size() == 0) begin
      chk("queue", 1, 0);
    end else begin
      nt = q.pop_front();
      chk("error", err, nt[1058]);
      chk("acc_we", we, nt[1057]);
      chk("contact", con, nt[1056]);
      chk("acc", acc_o, nt[1055:1024]);
      chk("out", out_pts, nt[1023:0]);
    end
  end
  // one op: note its expected outcome, then present it for one edge
  task go(input logic [3:0] o, input logic r, input logic [9:0] p, l,
          input logic [5:0] n, input logic [14:0] a, input logic [31:0] v);
    logic e, w;
    int i;
    w = 0;
    e = o == 0 || o > 9 || (o == 4 || o == 6) && (a < 15'h4100 ||
      a > 15'h413F) || (o == 5 || o == 7) && (n == 0 || n > 32);
    if (o == 1) begin
      cm[p] = cm[p] | r;
      eo[p] = cm[p];
    end
    if (o == 8 || o == 9) ec = r & (pts[p] ^ o[0]);
    if (!e && r) case (o)
      2, 3: for (i = p; i <= l; i++) eo[i] = (o == 2);
      4: begin
        ea = 32'(pts >> {a[5:0], 4'h0}) & 32'hFFFF;
        w = 1;
      end
      5: begin
        ea = 32'(pts >> p) & 32'((33'h1 << n) - 1);
        w = 1;
      end
      6: for (i = 0; i < 16; i++) eo[16 * a[5:0] + i] = v[i];
      7: for (i = 0; i < n; i++) eo[p + i] = v[i];
    endcase
    q.push_back({e, w, ec, ea, eo});
    ov <= 1; op <= o; rung <= r; pt <= p; lst <= l; cnt <= n;
    wa <= a; acc <= v; scan <= 0; nw <= 0;
    @(posedge clk);
  endtask
  // idle cycle: fresh input points, optional scan start
  task idle(input logic s);
    ov <= 0; scan <= s; nw <= 1;
    if (s) cm = 0;
    @(posedge clk);
  endtask
  initial begin
    logic [14:0] wt [4] = '{15'h40FF, 15'h4100, 15'h413F, 15'h4140};
    logic [9:0] p;
    void'($urandom(28));
    repeat (5) @(posedge clk);
    rst <= 0;
    idle(1);
    // coil ored across rungs in one scan, dropped after scan start
    go(1, 1, 5, 0, 0, 0, 0);
    go(1, 0, 5, 0, 0, 0, 0);
    idle(1);
    go(1, 0, 5, 0, 0, 0, 0);
    // latched set and clear, back to back, false rungs change nothing
    go(2, 1, 3, 40, 0, 0, 0);
    go(2, 0, 50, 60, 0, 0, 0);
    go(3, 1, 10, 20, 0, 0, 0);
    go(3, 0, 3, 5, 0, 0, 0);
    // every bit count on bit load and write, 0 and 33 refused
    for (int k = 0; k < 34; k++) begin
      go(5, 1, 10'(k * 29), 0, 6'(k), 0, 0);
      go(7, 1, 10'(k * 29), 0, 6'(k), 0, $urandom);
    end
    // word address window edges
    foreach (wt[j]) begin
      go(4, 1, 0, 0, 0, wt[j], 0);
      go(6, 1, 0, 0, 0, wt[j], $urandom);
    end
    // random mix of every code with fresh inputs in between
    repeat (300) begin
      p = 10'($urandom % 990);
      go(4'($urandom), 1'($urandom), p, p + 10'($urandom % 30),
         6'($urandom % 34), 15'h40F8 + 15'($urandom % 80), $urandom);
      if ($urandom % 4 == 0) idle($urandom % 3 == 0);
    end
    idle(0); idle(0); idle(0);
    if (q.size() != 0) fail_count++;
    report_and_stop;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop;
  end
endmodule // immediate_io_access_unit_tb_top

// [test/iou_io_mod.sv]
// iou_io_mod: model of the input module bank on the local base
// assumes: new pattern requested for one cycle; changes away from rising edge
`timescale 1ns/1ps
module iou_io_mod (
  input  wire          clk_i,
  input  wire          new_i,
  output logic [1023:0] pts_o
);
  // live inputs move on the falling edge so sampling never races
  initial begin
    pts_o = '0;
    forever begin
      @(negedge clk_i);
      if (new_i)
        for (int i = 0; i < 32; i++)
          pts_o[32 * i +: 32] = $urandom;
    end
  end
endmodule // iou_io_mod

// [test/iou_unit_chk_asserts.sv]
// iou_unit_chk: port-level checks of the immediate I/O access unit
// assumes: bound to iou_unit, one clock, synchronous active-high reset
`timescale 1ns/1ps
`include "iou_defs.vh"
module iou_unit_chk (
  input wire          core_clk_i,
  input wire          rst_i,
  input wire          op_valid_i,
  input wire          rung_i,
  input wire          op_ready_o,
  input wire          done_o,
  input wire          error_o,
  input wire          acc_we_o,
  input wire          contact_o,
  input wire [3:0]    op_i,
  input wire [9:0]    point_i,
  input wire [9:0]    last_i,
  input wire [5:0]    count_i,
  input wire [14:0]   waddr_i,
  input wire [31:0]   acc_i,
  input wire [31:0]   acc_o,
  input wire [1023:0] in_pts_i,
  input wire [1023:0] out_pts_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // qualified op, legal word address, legal bit count
  wire go  = op_valid_i && rung_i;
  wire aok = waddr_i >= `IOU_WADDR_LO && waddr_i <= `IOU_WADDR_HI;
  wire nok = count_i != 6'h00 && count_i <= `IOU_CNT_MAX;
  a_ready_high: assert property (op_ready_o)
    else $error("ready low");
  a_idle_quiet: assert property (!op_valid_i |=>
    !done_o && !acc_we_o && !error_o && $stable(out_pts_o))
    else $error("change without op");
  a_coil_on: assert property (go && op_i == `IOU_OP_COIL |=>
    out_pts_o[$past(point_i)]) else $error("coil point off");
  a_set_range: assert property (go && op_i == `IOU_OP_SET |=>
    out_pts_o[$past(point_i)] && out_pts_o[$past(last_i)])
    else $error("set range not on");
  a_clear_range: assert property (go && op_i == `IOU_OP_CLEAR |=>
    !out_pts_o[$past(point_i)] && !out_pts_o[$past(last_i)])
    else $error("clear range not off");
  a_ldw_refuse: assert property (go && op_i == `IOU_OP_LDW && !aok |=>
    error_o && !acc_we_o) else $error("bad word address taken");
  a_ldw_value: assert property (go && op_i == `IOU_OP_LDW && aok |=>
    acc_we_o && acc_o[15:0] ==
    16'($past(in_pts_i) >> {$past(waddr_i[5:0]), 4'h0}))
    else $error("word load value");
  a_ldb_value: assert property (go && op_i == `IOU_OP_LDB && nok
    && {1'b0, point_i} + count_i <= 11'd1024 |=> acc_we_o &&
    acc_o == (32'($past(in_pts_i) >> $past(point_i))
    & 32'((33'h1 << $past(count_i)) - 1))) else $error("bit load value");
  a_outw_value: assert property (go && op_i == `IOU_OP_OUTW && aok |=>
    16'(out_pts_o >> {$past(waddr_i[5:0]), 4'h0}) == $past(acc_i[15:0]))
    else $error("word write value");
  a_outw_bad: assert property (go && op_i == `IOU_OP_OUTW && !aok |=>
    error_o && $stable(out_pts_o)) else $error("bad word write taken");
  a_outb_low: assert property (go && op_i == `IOU_OP_OUTB && nok |=>
    out_pts_o[$past(point_i)] == $past(acc_i[0]))
    else $error("bit write low bit");
  a_contact_live: assert property (op_valid_i && op_i[3:1] == 3'h4
    |=> contact_o == $past(rung_i && (in_pts_i[point_i] ^ op_i[0])))
    else $error("contact value");
endmodule // iou_unit_chk
bind iou_unit iou_unit_chk u_chk (
  .core_clk_i (core_clk_i),
  .rst_i      (rst_i),
  .op_valid_i (op_valid_i),
  .rung_i     (rung_i),
  .op_ready_o (op_ready_o),
  .done_o     (done_o),
  .error_o    (error_o),
  .acc_we_o   (acc_we_o),
  .contact_o  (contact_o),
  .op_i       (op_i),
  .point_i    (point_i),
  .last_i     (last_i),
  .count_i    (count_i),
  .waddr_i    (waddr_i),
  .acc_i      (acc_i),
  .acc_o      (acc_o),
  .in_pts_i   (in_pts_i),
  .out_pts_o  (out_pts_o)
);
